// File: design/asrf_accum.v
// First-order sample accumulator for hardware averaging
`timescale 1ns/1ns
`include "asrf_regs.vh"

module asrf_accum
#(
  parameter SUM_W = 20
)
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Control
  input  wire        clr,
  input  wire        add,
  input  wire [3:0]  shift,
  input  wire [11:0] sample,
  // Average of the accumulated samples
  output wire [11:0] avg
);

  reg  [SUM_W-1:0] acc_q;
  wire [SUM_W-1:0] sum_d;
  wire [SUM_W-1:0] shifted;

  // Clear and add in one cycle starts a fresh sum with this sample
  assign sum_d   = (clr ? {SUM_W{1'b0}} : acc_q) + {{(SUM_W-12){1'b0}}, sample};
  assign shifted = sum_d >> shift;
  assign avg     = shifted[11:0];

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      acc_q <= {SUM_W{1'b0}};
    else if (add)
      acc_q <= sum_d;
    else if (clr)
      acc_q <= {SUM_W{1'b0}};
  end

endmodule // asrf_accum

// File: design/asrf_format.v
// Result word formatting: signedness, alignment and resolution
`timescale 1ns/1ns
`include "asrf_regs.vh"

module asrf_format
(
  // Raw code and formatting controls
  input  wire [11:0] code,
  input  wire [1:0]  res,
  input  wire        sgn,
  input  wire        gnd_mode,
  input  wire        left,
  // Formatted word
  output reg  [15:0] result
);

  reg [11:0] c;
  reg [11:0] msb;
  reg [11:0] v;

  always @*
  begin
    c   = code;
    msb = 12'h800;
    case (res)
      `ASRF_RES_10:
      begin
        c   = {2'h0, code[9:0]};
        msb = 12'h200;
      end
      `ASRF_RES_8:
      begin
        c   = {4'h0, code[7:0]};
        msb = 12'h080;
      end
      default:
      begin
        c   = code;
        msb = 12'h800;
      end
    endcase
    // Ground-referenced single-ended: lower half of the range is unreachable
    if (gnd_mode)
      v = ((c & msb) != 12'h000) ? (c ^ msb) : 12'h000;
    else if (sgn)
      v = c ^ msb;
    else
      v = c;
    if (left)
    begin
      // Low bits below the converted value are forced to zero
      case (res)
        `ASRF_RES_10: result = {v[9:0], 6'h00};
        `ASRF_RES_8:  result = {v[7:0], 8'h00};
        default:      result = {v, 4'h0};
      endcase
    end
    else if (sgn && !gnd_mode)
    begin
      case (res)
        `ASRF_RES_10: result = {{6{v[9]}}, v[9:0]};
        `ASRF_RES_8:  result = {{8{v[7]}}, v[7:0]};
        default:      result = {{4{v[11]}}, v};
      endcase
    end
    else
      result = {4'h0, v};
  end

endmodule // asrf_format

// File: design/asrf_top.v
// Scan sequencer, averaging and double-buffered results around a 12-bit converter
// Operation
// - Signed results sign-extend the top bit
// - Unsigned results are zero-extended to 16 bits
// - Separate signedness bits for differential and single-ended
// - Right alignment puts the value in low bits
// - Left alignment puts top bit at 15
// - Per-channel resolution of 8, 10 or 12
// - Sixteen channels, thirteen sources, one injection channel
// - Accumulate power-of-two sample counts, 2 to 256
// - Double-buffered results, end-of-scan flag
// - Overflow, collision, saturation, over-range flags raise interrupt
// - One-shot and free-running scan modes
// - Firmware, timer, comparators or end-of-scan trigger
// - Firmware-only injection channel, own settings, tailgates
// - Enabled channels scanned without processor help
// - Differential codes span 0 to 4095 unsigned
// - Differential or single-ended chosen per channel
// - Global negative input: ground, reference, pins
// - Temperature sensor forces negative select to zero
// - Ground negative ignores signedness, limits to 0x7FF
// - Conversion takes resolution plus two clocks
`timescale 1ns/1ns
`include "asrf_regs.vh"

module asrf_top
#(
  parameter NCH     = 16,
  parameter SAR_DIV = `ASRF_SAR_DIV
)
(
  // Clock and reset
  input  wire           ref_clk,
  input  wire           rst,
  // Scan control
  input  wire [NCH-1:0] chan_en,
  input  wire           free_run,
  input  wire [2:0]     trig_sel,
  input  wire           trig_fw,
  input  wire           trig_timer,
  input  wire           trig_amp_cmp,
  input  wire           trig_lp_cmp,
  // Global configuration
  input  wire [1:0]     sample_signed,
  input  wire           left_align,
  input  wire [2:0]     neg_sel,
  input  wire [2:0]     neg_pin,
  input  wire [3:0]     avg_shift,
  input  wire [39:0]    acq_times,
  input  wire [15:0]    range_lo,
  input  wire [15:0]    range_hi,
  // Per-channel configuration, packed by channel
  input  wire [NCH*4-1:0] chan_src,
  input  wire [NCH-1:0] chan_diff,
  input  wire [NCH*2-1:0] chan_res,
  input  wire [NCH*2-1:0] chan_acq,
  input  wire [NCH-1:0] chan_avg,
  input  wire [NCH-1:0] chan_range_en,
  // Injection channel
  input  wire           inj_req,
  input  wire [3:0]     inj_src,
  input  wire           inj_diff,
  input  wire [1:0]     inj_res,
  input  wire [1:0]     inj_acq,
  input  wire           inj_avg,
  input  wire           inj_range_en,
  // Converter and input multiplexer
  input  wire [11:0]    core_data,
  output reg  [3:0]     adc_input_mux_q,
  output reg            mux_diff_q,
  output reg  [2:0]     neg_sel_out_q,
  output reg  [2:0]     neg_pin_out_q,
  output reg  [1:0]     core_res_q,
  output reg            core_sample_q,
  output reg            core_start_q,
  // Result read port
  input  wire           rd_en,
  input  wire [4:0]     rd_chan,
  output reg  [15:0]    rd_data_q,
  output reg            rd_valid_q,
  // Status
  input  wire [4:0]     flag_clr,
  input  wire [4:0]     flag_mask,
  output reg  [4:0]     flags_q,
  output reg            irq_q,
  output reg            busy_q
);

  localparam S_IDLE  = 4'h1;
  localparam S_ACQ   = 4'h2;
  localparam S_CONV  = 4'h4;
  localparam S_STORE = 4'h8;

  // Next enabled channel strictly after cur, or the lowest one if from_start, or none
  function [4:0] next_chan;
    input [NCH-1:0] en;
    input [4:0]     cur;
    input           from_start;
    integer         i;
    reg             found;
    begin
      next_chan = `ASRF_NO_CHAN;
      found     = 1'b0;
      for (i = 0; i < NCH; i = i + 1)
        if (!found && en[i] && (from_start || (i > cur)))
        begin
          next_chan = i[4:0];
          found     = 1'b1;
        end
    end
  endfunction

  function [3:0] res_bits;
    input [1:0] r;
    begin
      case (r)
        `ASRF_RES_10: res_bits = `ASRF_BITS_10;
        `ASRF_RES_8:  res_bits = `ASRF_BITS_8;
        default:      res_bits = `ASRF_BITS_12;
      endcase
    end
  endfunction

  reg [3:0]  state_q;
  reg [7:0]  div_q;
  reg        tick_q;
  reg [4:0]  chan_q;
  reg        inj_q;
  reg        inj_pend_q;
  reg [9:0]  acq_cnt_q;
  reg [3:0]  conv_cnt_q;
  reg [8:0]  samp_cnt_q;
  reg        first_q;
  reg        eos_q;
  reg [15:0] result_q [0:NCH];
  reg [NCH:0] valid_q;
  reg [11:0] last_avg_q;

  wire [3:0]  c_src;
  wire        c_diff;
  wire [1:0]  c_res;
  wire [1:0]  c_acq;
  wire        c_avg;
  wire        c_range;
  wire        is_temp;
  wire        gnd_mode;
  wire        sgn;
  wire [9:0]  acq_len;
  wire [8:0]  samp_need;
  wire [11:0] avg;
  wire [15:0] fmt;
  wire        trig;
  wire [4:0]  first_ch;
  wire [4:0]  next_ch;
  wire [11:0] res_max;
  wire [4:0]  set;

  // Active channel settings, injection slot has its own
  assign c_src   = inj_q ? inj_src : chan_src[chan_q[3:0]*4 +: 4];
  assign c_diff  = inj_q ? inj_diff : chan_diff[chan_q[3:0]];
  assign c_res   = inj_q ? inj_res : chan_res[chan_q[3:0]*2 +: 2];
  assign c_acq   = inj_q ? inj_acq : chan_acq[chan_q[3:0]*2 +: 2];
  assign c_avg   = inj_q ? inj_avg : chan_avg[chan_q[3:0]];
  assign c_range = inj_q ? inj_range_en : chan_range_en[chan_q[3:0]];
  assign acq_len = acq_times[c_acq*10 +: 10];
  // Temperature sensor is single-ended only, with the negative field forced
  assign is_temp  = (c_src == `ASRF_SRC_TEMP);
  assign gnd_mode = !c_diff && (is_temp || (neg_sel == `ASRF_NEG_VSSA));
  assign sgn = c_diff && !is_temp ? sample_signed[`ASRF_SGN_DIFF]
                                  : sample_signed[`ASRF_SGN_SE];
  assign samp_need = c_avg ? (9'h001 << avg_shift) : 9'h001;
  assign res_max   = (12'hFFF >> (4'hC - res_bits(c_res)));

  assign trig = (trig_sel == `ASRF_TRIG_FW)    ? trig_fw :
                (trig_sel == `ASRF_TRIG_TIMER) ? trig_timer :
                (trig_sel == `ASRF_TRIG_AMP)   ? trig_amp_cmp :
                (trig_sel == `ASRF_TRIG_LPCMP) ? trig_lp_cmp :
                (trig_sel == `ASRF_TRIG_EOC)   ? eos_q : 1'b0;

  assign first_ch = next_chan(chan_en, 5'h00, 1'b1);
  assign next_ch  = next_chan(chan_en, chan_q, 1'b0);

  asrf_accum #(.SUM_W(20)) u_accum
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clr     (first_q),
    .add     ((state_q == S_CONV) && tick_q && (conv_cnt_q == 4'h1)),
    .shift   (c_avg ? avg_shift : 4'h0),
    .sample  (core_data),
    .avg     (avg)
  );

  asrf_format u_format
  (
    .code     (last_avg_q),
    .res      (c_res),
    .sgn      (sgn),
    .gnd_mode (gnd_mode),
    .left     (left_align),
    .result   (fmt)
  );

  // Event sources for the sticky flags
  assign set[`ASRF_FLG_EOS]   = eos_q;
  assign set[`ASRF_FLG_OVF]   = (state_q == S_STORE) && valid_q[chan_q];
  assign set[`ASRF_FLG_COLL]  = (state_q != S_IDLE) && trig && !free_run;
  assign set[`ASRF_FLG_SAT]   = (state_q == S_STORE) &&
                                ((last_avg_q == 12'h000) || (last_avg_q == res_max));
  assign set[`ASRF_FLG_RANGE] = (state_q == S_STORE) && c_range &&
                                ((fmt < range_lo) || (fmt > range_hi));

  // Converter clock enable from the divider
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (div_q == SAR_DIV - 8'h01)
    begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q         <= S_IDLE;
      chan_q          <= 5'h00;
      inj_q           <= 1'b0;
      inj_pend_q      <= 1'b0;
      acq_cnt_q       <= 10'h000;
      conv_cnt_q      <= 4'h0;
      samp_cnt_q      <= 9'h000;
      first_q         <= 1'b0;
      eos_q           <= 1'b0;
      last_avg_q      <= 12'h000;
      core_sample_q   <= 1'b0;
      core_start_q    <= 1'b0;
      busy_q          <= 1'b0;
      adc_input_mux_q <= 4'h0;
      mux_diff_q      <= 1'b0;
      neg_sel_out_q   <= `ASRF_NEG_VSSA;
      neg_pin_out_q   <= 3'h0;
      core_res_q      <= `ASRF_RES_12;
    end
    else
    begin
      eos_q        <= 1'b0;
      core_start_q <= 1'b0;
      // Injection request waits for the running scan to finish
      if (inj_req)
        inj_pend_q <= 1'b1;
      case (state_q)
        S_IDLE:
        begin
          busy_q <= 1'b0;
          if (inj_pend_q || inj_req)
          begin
            inj_q      <= 1'b1;
            inj_pend_q <= 1'b0;
            chan_q     <= `ASRF_INJ_SLOT;
            state_q    <= S_ACQ;
            first_q    <= 1'b1;
            samp_cnt_q <= 9'h000;
            busy_q     <= 1'b1;
          end
          else if ((free_run || trig) && (first_ch != `ASRF_NO_CHAN))
          begin
            inj_q      <= 1'b0;
            chan_q     <= first_ch;
            state_q    <= S_ACQ;
            first_q    <= 1'b1;
            samp_cnt_q <= 9'h000;
            busy_q     <= 1'b1;
          end
        end
        S_ACQ:
        begin
          // Drive mux and core from the active channel
          adc_input_mux_q <= c_src;
          mux_diff_q      <= c_diff && !is_temp;
          neg_sel_out_q   <= is_temp ? `ASRF_NEG_VSSA : neg_sel;
          neg_pin_out_q   <= neg_pin;
          core_res_q      <= c_res;
          core_sample_q   <= 1'b1;
          if (!core_sample_q)
            acq_cnt_q <= acq_len;
          else if (tick_q)
          begin
            if (acq_cnt_q <= 10'h001)
            begin
              core_sample_q <= 1'b0;
              core_start_q  <= 1'b1;
              conv_cnt_q    <= res_bits(c_res) + `ASRF_CONV_EXTRA;
              state_q       <= S_CONV;
            end
            else
              acq_cnt_q <= acq_cnt_q - 10'h001;
          end
        end
        S_CONV:
        begin
          if (tick_q)
          begin
            conv_cnt_q <= conv_cnt_q - 4'h1;
            if (conv_cnt_q == 4'h1)
            begin
              // Accumulated code shifted by the averaging count, raw core code when averaging is off
              first_q    <= 1'b0;
              last_avg_q <= avg;
              samp_cnt_q <= samp_cnt_q + 9'h001;
              if (samp_cnt_q + 9'h001 >= samp_need)
                state_q <= S_STORE;
              else
                state_q <= S_ACQ;
            end
          end
        end
        S_STORE:
        begin
          first_q    <= 1'b1;
          samp_cnt_q <= 9'h000;
          if (!inj_q && (next_ch != `ASRF_NO_CHAN))
          begin
            chan_q  <= next_ch;
            state_q <= S_ACQ;
          end
          else
          begin
            eos_q   <= !inj_q;
            inj_q   <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Visible buffer loads only when a channel completes
  always @(posedge ref_clk)
  begin
    if (state_q == S_STORE)
      result_q[chan_q] <= fmt;
  end

  // Valid bits: a new result wins over a read in the same cycle
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      valid_q    <= {(NCH+1){1'b0}};
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
      flags_q    <= 5'h00;
      irq_q      <= 1'b0;
    end
    else
    begin
      if (rd_en && (rd_chan <= `ASRF_INJ_SLOT))
      begin
        rd_data_q  <= valid_q[rd_chan] ? result_q[rd_chan] : 16'h0000;
        rd_valid_q <= valid_q[rd_chan];
        valid_q[rd_chan] <= 1'b0;
      end
      else
        rd_valid_q <= 1'b0;
      if (state_q == S_STORE)
        valid_q[chan_q] <= 1'b1;
      flags_q <= (flags_q & ~flag_clr) | set;
      irq_q   <= |(((flags_q & ~flag_clr) | set) & flag_mask);
    end
  end

endmodule // asrf_top

// File: include/asrf_regs.vh
// Constants for the scan sequencer and result formatter
`ifndef ASRF_REGS_VH
`define ASRF_REGS_VH

// Resolution codes per channel
`define ASRF_RES_12      2'h0
`define ASRF_RES_10      2'h1
`define ASRF_RES_8       2'h2
`define ASRF_BITS_12     4'hC
`define ASRF_BITS_10     4'hA
`define ASRF_BITS_8      4'h8
// Extra converter clocks beyond one per bit
`define ASRF_CONV_EXTRA  4'h2

// Global negative input field codes
`define ASRF_NEG_VSSA    3'h0
`define ASRF_NEG_VREF    3'h1
`define ASRF_NEG_PIN     3'h2

// Input source code of the temperature sensor
`define ASRF_SRC_TEMP    4'hC

// Signedness bits of the sample control field
`define ASRF_SGN_DIFF    1
`define ASRF_SGN_SE      0

// Trigger source codes
`define ASRF_TRIG_FW     3'h0
`define ASRF_TRIG_TIMER  3'h1
`define ASRF_TRIG_AMP    3'h2
`define ASRF_TRIG_LPCMP  3'h3
`define ASRF_TRIG_EOC    3'h4

// Result slots: sixteen channels, then injection
`define ASRF_INJ_SLOT    5'h10
`define ASRF_NO_CHAN     5'h1F

// Status flag positions
`define ASRF_FLG_EOS     0
`define ASRF_FLG_OVF     1
`define ASRF_FLG_COLL    2
`define ASRF_FLG_SAT     3
`define ASRF_FLG_RANGE   4

// Converter clock divider from ref_clk: 250 MHz / 14 is under 18 MHz
`define ASRF_SAR_DIV     8'h0E
// Averaging shift of 1 means 2 samples, 8 means 256
`define ASRF_AVG_MIN_SH  4'h1

`endif

// File: sim/asrf_tb.sv
// Self-checking testbench for the scan sequencer and result formatter
`timescale 1ns/1ns

module tb;
  // Stimulus
  reg         ref_clk, rst, free_run, trig_fw, trig_timer, trig_amp_cmp, trig_lp_cmp;
  reg         left_align, inj_req, inj_diff, inj_avg, inj_range_en, rd_en;
  reg  [1:0]  sample_signed, inj_res, inj_acq;
  reg  [2:0]  trig_sel, neg_sel, neg_pin;
  reg  [3:0]  avg_shift, inj_src;
  reg  [4:0]  rd_chan, flag_clr, flag_mask;
  reg  [11:0] core_data;
  reg  [15:0] chan_en, chan_diff, chan_avg, chan_range_en, range_lo, range_hi;
  reg  [31:0] chan_res, chan_acq;
  reg  [39:0] acq_times;
  reg  [63:0] chan_src;
  // Observed
  wire        mux_diff_q, core_sample_q, core_start_q, rd_valid_q, irq_q, busy_q;
  wire [3:0]  adc_input_mux_q;
  wire [2:0]  neg_sel_out_q, neg_pin_out_q;
  wire [1:0]  core_res_q;
  wire [15:0] rd_data_q;
  wire [4:0]  flags_q;
  integer     err_total, comparisons;

  // Small divider keeps scans short
  asrf_top #(.NCH(16), .SAR_DIV(2)) i_dut (.ref_clk, .rst, .chan_en, .free_run, .trig_sel,
    .trig_fw, .trig_timer, .trig_amp_cmp, .trig_lp_cmp, .sample_signed, .left_align, .neg_sel,
    .neg_pin, .avg_shift, .acq_times, .range_lo, .range_hi, .chan_src, .chan_diff, .chan_res,
    .chan_acq, .chan_avg, .chan_range_en, .inj_req, .inj_src, .inj_diff, .inj_res, .inj_acq,
    .inj_avg, .inj_range_en, .core_data, .adc_input_mux_q, .mux_diff_q, .neg_sel_out_q,
    .neg_pin_out_q, .core_res_q, .core_sample_q, .core_start_q, .rd_en, .rd_chan, .rd_data_q,
    .rd_valid_q, .flag_clr, .flag_mask, .flags_q, .irq_q, .busy_q);

  always #2 ref_clk = ~ref_clk;

  task conclude;
  begin
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task cmp(input string what, input [15:0] exp, input [15:0] got);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  // Inputs always move one ns after the rising edge
  task tick;
  begin
    @(posedge ref_clk);
    #1;
  end
  endtask

  task fire_fw;
  begin
    tick;
    trig_fw = 1'b1;
    tick;
    trig_fw = 1'b0;
  end
  endtask

  // Two passes, since busy may rise an edge late or dip between scan and injection
  task wait_idle;
    integer n;
  begin
    n = 0;
    repeat (2)
    begin
      while (busy_q !== 1'b0 && n < 30000)
      begin
        tick;
        n = n + 1;
      end
      repeat (4) tick;
    end
    cmp("busy", 16'h0000, {15'h0, busy_q});
  end
  endtask

  task rd(input [4:0] ch, input vld, input [15:0] exp);
  begin
    tick;
    rd_en = 1'b1;
    rd_chan = ch;
    tick;
    rd_en = 1'b0;
    cmp("rd_valid", {15'h0, vld}, {15'h0, rd_valid_q});
    cmp("rd_data", exp, rd_data_q);
  end
  endtask

  task run_fmt(input [1:0] res, input dif, input [1:0] sg, input lft, input [2:0] ng,
               input [11:0] code, input [15:0] exp);
  begin
    chan_en = 16'h0001;
    chan_res[1:0] = res;
    chan_diff[0] = dif;
    sample_signed = sg;
    left_align = lft;
    neg_sel = ng;
    core_data = code;
    fire_fw;
    wait_idle;
    rd(5'h00, 1'b1, exp);
  end
  endtask

  task t_format;
  begin
    run_fmt(2'h0, 1'b1, 2'h2, 1'b0, 3'h1, 12'h123, 16'hF923);
    run_fmt(2'h0, 1'b1, 2'h1, 1'b0, 3'h1, 12'hABC, 16'h0ABC);
    run_fmt(2'h0, 1'b0, 2'h1, 1'b0, 3'h1, 12'hABC, 16'h02BC);
    run_fmt(2'h1, 1'b1, 2'h0, 1'b0, 3'h1, 12'h3FF, 16'h03FF);
    run_fmt(2'h2, 1'b1, 2'h2, 1'b0, 3'h1, 12'h005, 16'hFF85);
    run_fmt(2'h0, 1'b1, 2'h0, 1'b1, 3'h1, 12'hABC, 16'hABC0);
    run_fmt(2'h1, 1'b1, 2'h0, 1'b1, 3'h1, 12'h2AB, 16'hAAC0);
    run_fmt(2'h2, 1'b1, 2'h0, 1'b1, 3'h1, 12'h0A5, 16'hA500);
    run_fmt(2'h0, 1'b0, 2'h1, 1'b0, 3'h0, 12'hFFF, 16'h07FF);
    run_fmt(2'h0, 1'b0, 2'h1, 1'b0, 3'h0, 12'h3FF, 16'h0000);
    run_fmt(2'h0, 1'b0, 2'h0, 1'b0, 3'h2, 12'h800, 16'h0800);
    $display("test format done");
  end
  endtask

  task t_scan;
  begin
    flag_clr = 5'h1F;
    tick;
    flag_clr = 5'h00;
    tick;
    cmp("flags", 16'h0000, {11'h0, flags_q});
    flag_mask = 5'h01;
    chan_en = 16'h800A;
    chan_diff = 16'h000A;
    chan_res = 32'h0000_0080;
    chan_src = 64'hC000_0000_0000_3010;
    chan_acq = 32'hFFFF_FFFF;
    sample_signed = 2'h0;
    left_align = 1'b0;
    neg_sel = 3'h1;
    core_data = 12'h0F5;
    fire_fw;
    wait_idle;
    cmp("flags", 16'h0001, {11'h0, flags_q});
    cmp("irq", 16'h0001, {15'h0, irq_q});
    cmp("neg_sel_out", 16'h0000, {13'h0, neg_sel_out_q});
    rd(5'h01, 1'b1, 16'h00F5);
    rd(5'h03, 1'b1, 16'h00F5);
    rd(5'h0F, 1'b1, 16'h0000);
    rd(5'h02, 1'b0, 16'h0000);
    rd(5'h01, 1'b0, 16'h0000);
    rd(5'h11, 1'b0, 16'h0000);
    flag_mask = 5'h00;
    tick;
    cmp("irq", 16'h0000, {15'h0, irq_q});
    fire_fw;
    wait_idle;
    fire_fw;
    wait_idle;
    cmp("overflow", 16'h0002, {11'h0, flags_q & 5'h02});
    $display("test scan done");
  end
  endtask

  task t_avg;
  begin
    chan_en = 16'h0001;
    chan_avg = 16'h0001;
    chan_diff = 16'h0001;
    chan_res = 32'h0;
    flag_clr = 5'h1F;
    avg_shift = 4'h1;
    core_data = 12'hFFF;
    fire_fw;
    flag_clr = 5'h00;
    wait_idle;
    rd(5'h00, 1'b1, 16'h0FFF);
    cmp("saturation", 16'h0008, {11'h0, flags_q & 5'h08});
    avg_shift = 4'h8;
    core_data = 12'h321;
    fire_fw;
    wait_idle;
    rd(5'h00, 1'b1, 16'h0321);
    rd(5'h00, 1'b0, 16'h0000);
    chan_avg = 16'h0000;
    $display("test averaging done");
  end
  endtask

  task t_inj;
  begin
    core_data = 12'h456;
    inj_src = 4'h5;
    inj_diff = 1'b1;
    inj_res = 2'h2;
    inj_acq = 2'h1;
    inj_range_en = 1'b1;
    range_hi = 16'h0050;
    neg_pin = 3'h5;
    fire_fw;
    inj_req = 1'b1;
    tick;
    inj_req = 1'b0;
    trig_fw = 1'b1;
    tick;
    trig_fw = 1'b0;
    wait_idle;
    rd(5'h00, 1'b1, 16'h0456);
    rd(5'h10, 1'b1, 16'h0056);
    cmp("collision", 16'h0004, {11'h0, flags_q & 5'h04});
    cmp("over-range", 16'h0010, {11'h0, flags_q & 5'h10});
    cmp("mux", 16'h0005, {12'h0, adc_input_mux_q});
    cmp("mux_diff", 16'h0001, {15'h0, mux_diff_q});
    cmp("core_res", 16'h0002, {14'h0, core_res_q});
    cmp("neg_sel_out", 16'h0001, {13'h0, neg_sel_out_q});
    cmp("neg_pin", 16'h0005, {13'h0, neg_pin_out_q});
    $display("test injection done");
  end
  endtask

  task t_trig;
    integer s;
  begin
    for (s = 1; s < 4; s = s + 1)
    begin
      trig_sel = s[2:0];
      trig_timer = (s == 1);
      trig_amp_cmp = (s == 2);
      trig_lp_cmp = (s == 3);
      tick;
      {trig_timer, trig_amp_cmp, trig_lp_cmp} = 3'h0;
      wait_idle;
      rd(5'h00, 1'b1, 16'h0456);
    end
    trig_sel = 3'h1;
    trig_lp_cmp = 1'b1;
    tick;
    trig_lp_cmp = 1'b0;
    repeat (60) tick;
    rd(5'h00, 1'b0, 16'h0000);
    trig_sel = 3'h0;
    $display("test triggers done");
  end
  endtask

  task t_free;
  begin
    free_run = 1'b1;
    repeat (300) tick;
    rd(5'h00, 1'b1, 16'h0456);
    repeat (100) tick;
    rd(5'h00, 1'b1, 16'h0456);
    // Own end-of-scan as trigger keeps scanning after free run stops
    trig_sel = 3'h4;
    free_run = 1'b0;
    repeat (100) tick;
    cmp("busy", 16'h0001, {15'h0, busy_q});
    trig_sel = 3'h0;
    wait_idle;
    repeat (60) tick;
    cmp("busy", 16'h0000, {15'h0, busy_q});
    fire_fw;
    repeat (10) tick;
    rst = 1'b1;
    tick;
    cmp("reset flags", 16'h0000, {10'h0, busy_q, flags_q});
    rst = 1'b0;
    rd(5'h00, 1'b0, 16'h0000);
    $display("test free run and reset done");
  end
  endtask

  initial
  begin
    err_total = 0;
    comparisons = 0;
    ref_clk = 1'b0;
    rst = 1'b1;
    {free_run, trig_fw, trig_timer, trig_amp_cmp, trig_lp_cmp, left_align, inj_req, inj_diff,
     inj_avg, inj_range_en, rd_en, sample_signed, inj_res, inj_acq, trig_sel, neg_pin, avg_shift,
     inj_src, rd_chan, flag_clr, flag_mask, core_data, chan_en, chan_diff, chan_avg,
     chan_range_en, range_lo, range_hi, chan_res, chan_acq, chan_src} = '0;
    neg_sel = 3'h1;
    acq_times = {4{10'h004}};
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_format;
    t_scan;
    t_avg;
    t_inj;
    t_trig;
    t_free;
    conclude;
  end

  // Longest test is the 256-sample average, about 9.2k cycles
  initial
  begin
    #400000;
    err_total = err_total + 1;
    $display("ERROR watchdog expected done seen hang");
    conclude;
  end

endmodule // tb

// File: sim/asrf_top_sva.sv
// Checker for scan timing, read port and status flags of the result formatter
`timescale 1ns/1ns
`include "asrf_regs.vh"

module asrf_top_sva
#(
  parameter NCH     = 16,
  parameter SAR_DIV = `ASRF_SAR_DIV
)
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Requests
  input wire logic       rd_en,
  input wire logic [4:0] flag_clr,
  input wire logic [4:0] flag_mask,
  // Observed outputs
  input wire logic [3:0] adc_input_mux_q,
  input wire logic [2:0] neg_sel_out_q,
  input wire logic       core_sample_q,
  input wire logic       core_start_q,
  input wire logic       rd_valid_q,
  input wire logic [4:0] flags_q,
  input wire logic       irq_q,
  input wire logic       busy_q
);
  // Shortest conversion is 8 bits plus two, ten ticks; one tick of slack for divider phase
  localparam int GAP_MIN = 9 * SAR_DIV;
  logic [9:0] gap_q;
  logic       seen_q;

  // Cycles since the last conversion start, saturating
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gap_q  <= 10'h000;
      seen_q <= 1'b0;
    end
    else if (core_start_q)
    begin
      gap_q  <= 10'h000;
      seen_q <= 1'b1;
    end
    else if (gap_q != 10'h3FF)
      gap_q <= gap_q + 10'h001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_read_answer: assert property (rd_valid_q |-> $past(rd_en))
    else $error("read valid without a read request");
  chk_irq_follow: assert property (irq_q == |(flags_q & $past(flag_mask)))
    else $error("interrupt does not follow masked flags");
  chk_flag_sticky: assert property (($past(flags_q) & ~flags_q & ~$past(flag_clr)) == 5'h00)
    else $error("status flag dropped without a clear");
  chk_temp_neg: assert property (core_sample_q && adc_input_mux_q == `ASRF_SRC_TEMP
    |-> neg_sel_out_q == `ASRF_NEG_VSSA)
    else $error("negative select not forced for temperature sensor");
  chk_start_pulse: assert property (core_start_q |=> !core_start_q)
    else $error("conversion start longer than one cycle");
  chk_start_order: assert property ($rose(core_start_q) |-> $past(core_sample_q) && !core_sample_q)
    else $error("conversion start not at end of acquisition");
  chk_conv_gap: assert property ($rose(core_sample_q) && seen_q |-> gap_q >= GAP_MIN)
    else $error("acquisition restarted before conversion time");
  chk_idle_quiet: assert property (!busy_q |-> !core_sample_q && !core_start_q)
    else $error("converter driven while idle");
  chk_mux_hold: assert property (core_sample_q && $past(core_sample_q)
    |-> $stable(adc_input_mux_q) && $stable(neg_sel_out_q))
    else $error("input select moved during acquisition");

endmodule // asrf_top_sva

bind asrf_top asrf_top_sva #(.NCH(NCH), .SAR_DIV(SAR_DIV)) i_sva (.ref_clk, .rst, .rd_en,
  .flag_clr, .flag_mask, .adc_input_mux_q, .neg_sel_out_q, .core_sample_q, .core_start_q,
  .rd_valid_q, .flags_q, .irq_q, .busy_q);
